/* bench/asrp_host_tb.sv */
// Self-checking bench for the static RAM host controller.
// Assumes the memory model stands on the pins and the bench resolves data.
`timescale 1ns/1ns
module asrp_host_tb;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic req_valid = 1'b0;
    logic req_ready;
    asrp_pkg::asrp_req_t req = '0;
    logic rsp_valid;
    logic [asrp_pkg::DATA_W-1:0] rsp_data, data_out, data_in, dq;
    asrp_pkg::asrp_pins_t pins;
    logic data_oe, dq_oe, sel;
    logic prev_sel = 1'b0;
    logic [asrp_pkg::ADDR_W-1:0] prev_addr = '0;
    logic [asrp_pkg::ADDR_W-1:0] acc_addr = '0;
    int mismatches = 0;
    int checks = 0;
    int cyc = 0;
    int exp_mem [int];
    int exp_q [$];
    int acc_q [$];
    logic [asrp_pkg::ADDR_W-1:0] wq [$];

    asrp_host dut (.core_clk(core_clk), .reset_n(reset_n), .req_valid(req_valid), .req_ready(req_ready),
        .req(req), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .pins(pins), .data_out(data_out),
        .data_oe(data_oe), .data_in(data_in));
    asrp_sram_model sram (.pins(pins), .bus_in(data_in), .dq(dq), .dq_oe(dq_oe));
    assign data_in = data_oe ? data_out : dq;
    assign sel = !pins.select_active_low && pins.select_active_high;

    initial forever #5 core_clk = ~core_clk;

    task check(input logic ok, input string msg);
        checks++;
        if (!ok) begin
            mismatches++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask

    task end_sim;
        if (mismatches == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task do_req(input logic w, input logic [asrp_pkg::ADDR_W-1:0] a, input logic [asrp_pkg::DATA_W-1:0] d);
        int n;
        n = 0;
        req_valid = 1'b1;
        req = {w, a, d};
        while (req_ready !== 1'b1 && n < 50) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        check(n < 50, "request not taken");
        @(posedge core_clk);
        #1;
        if (w) wq.push_back(a);
    endtask

    task idle(input int c);
        req_valid = 1'b0;
        repeat (c) begin
            @(posedge core_clk);
            #1;
        end
    endtask

    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            acc_q.delete();
            exp_q.delete();
        end else begin
            cyc++;
            if (req_valid && req_ready) begin
                acc_addr <= req.addr;
                if (req.write) exp_mem[req.addr] = req.wdata;
                else begin
                    acc_q.push_back(cyc);
                    exp_q.push_back(exp_mem[req.addr]);
                end
            end
            if (rsp_valid === 1'b1) check(exp_q.size() > 0, "unexpected read data");
            if (rsp_valid === 1'b1 && exp_q.size() > 0) begin
                check((cyc - acc_q[0]) inside {6, 7}, "read latency");
                check(rsp_data === 9'(exp_q[0]), "read data");
                void'(acc_q.pop_front());
                void'(exp_q.pop_front());
            end
            check(!(data_oe === 1'b1 && dq_oe === 1'b1), "data line contention");
            if (sel === 1'b1) check(pins.word_address_lines === prev_addr, "address moved");
            if (sel === 1'b1 && prev_sel !== 1'b1) check(pins.word_address_lines === acc_addr, "address at select");
            prev_sel <= sel;
            prev_addr <= pins.word_address_lines;
        end
    end

    initial begin
        int k;
        void'($urandom(32'h7352));
        repeat (16) @(posedge core_clk);
        #1;
        reset_n = 1'b1;
        check(pins === {4'hB, 15'h0000} && data_oe === 1'b0, "idle pins");
        do_req(1'b1, 15'h0000, 9'h1FF);
        do_req(1'b1, 15'h7FFF, 9'h0AA);
        do_req(1'b0, 15'h0000, 9'h000);
        do_req(1'b0, 15'h7FFF, 9'h000);
        for (k = 0; k < 300; k++) begin
            if ($urandom % 2)
                do_req(1'b1, ($urandom % 4) ? wq[$urandom % wq.size()] : 15'($urandom), 9'($urandom));
            else
                do_req(1'b0, wq[$urandom % wq.size()], 9'($urandom));
            if ($urandom % 4 == 0) idle($urandom % 3 + 1);
        end
        idle(10);
        reset_n = 1'b0;
        idle(3);
        reset_n = 1'b1;
        idle(1);
        check(pins === {4'hB, 15'h0000} && data_oe === 1'b0, "idle after reset");
        do_req(1'b0, wq[0], 9'h000);
        idle(10);
        check(exp_q.size() == 0, "missing read data");
        end_sim;
    end

    initial begin
        #200000;
        mismatches++;
        end_sim;
    end
endmodule

/* bench/asrp_sram_model.sv */
// Behavioural 32K x 9 asynchronous static memory on the host pins.
// Assumes the bench resolves the shared data wire and feeds it back.
`timescale 1ns/1ns
module asrp_sram_model (
    input wire asrp_pkg::asrp_pins_t pins, // Control and address
    input wire logic [asrp_pkg::DATA_W-1:0] bus_in, // Resolved data lines
    output logic [asrp_pkg::DATA_W-1:0] dq, // Memory drive value
    output logic dq_oe // Memory drives lines
);
    logic [asrp_pkg::DATA_W-1:0] mem [asrp_pkg::WORDS];
    logic [asrp_pkg::DATA_W-1:0] last = 9'h000;
    logic sel;
    logic wr;
    logic standby;
    assign sel = !pins.select_active_low && pins.select_active_high;
    assign standby = !sel;
    assign wr = sel && !pins.write_strobe_n;
    assign dq_oe = sel && pins.write_strobe_n && !pins.output_gate_n;
    // Released lines show the inverse of the last driven word
    assign dq = dq_oe ? mem[pins.word_address_lines] : ~last;
    always @(negedge wr) mem[pins.word_address_lines] = bus_in;
    // Word about to be driven, remembered for the released level
    always @(posedge dq_oe) last = mem[pins.word_address_lines];
endmodule

/* src/asrp_host.sv */
// Host-side controller driving an asynchronous 32K x 9 static RAM.
// Assumes the testbench resolves the shared data wire from the enables.
//
// Overview of operation
// - Write: active-low select low, active-high select high, write strobe low.
// - Read: active-low select and output gate low, strobe and active-high select high.
// - Write data captured at terminating rising edge; host holds data around it.
// - Host never drives data lines while the memory drives them.
// - Address valid before or with select assertion for a read.
`timescale 1ns/1ns
module asrp_host (
    input wire logic core_clk, // Core clock, 100 MHz
    input wire logic reset_n, // Async reset, active low
    input wire logic req_valid, // Request present
    output logic req_ready, // Request accepted this cycle
    input wire asrp_pkg::asrp_req_t req, // Request fields
    output logic rsp_valid, // Read data valid pulse
    output logic [asrp_pkg::DATA_W-1:0] rsp_data, // Read data
    output asrp_pkg::asrp_pins_t pins, // Control and address pins
    output logic [asrp_pkg::DATA_W-1:0] data_out, // Data lines drive value
    output logic data_oe, // Host drives data lines
    input wire logic [asrp_pkg::DATA_W-1:0] data_in // Data lines sensed
);
    typedef enum logic [2:0] {
        ASRP_IDLE, ASRP_RD_SETUP, ASRP_RD_WAIT, ASRP_WR_SETUP, ASRP_WR_PULSE, ASRP_WR_HOLD
    } asrp_state_t;

    asrp_state_t state;
    logic [3:0] cnt;
    logic [asrp_pkg::ADDR_W-1:0] word_addr;
    logic sel_lo_n;
    logic sel_hi;
    logic strobe_n;
    logic gate_n;
    logic [asrp_pkg::DATA_W-1:0] data_sync;

    function automatic logic [3:0] cyc(input int n);
        cyc = n[3:0];
    endfunction

    asrp_sync #(.W(asrp_pkg::DATA_W)) u_sync (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .d(data_in),
        .q(data_sync)
    );

    assign req_ready = (state == ASRP_IDLE);

    // Pin struct gathered from one register per concern
    assign pins = {sel_lo_n, sel_hi, gate_n, strobe_n, word_addr};

    // Sequencer; address is set a cycle before select so it leads the select
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= ASRP_IDLE;
            cnt <= asrp_pkg::CNT_ZERO;
        end else begin
            case (state)
                ASRP_IDLE: begin
                    if (req_valid) begin
                        state <= req.write ? ASRP_WR_SETUP : ASRP_RD_SETUP;
                    end
                end
                ASRP_RD_SETUP: begin
                    state <= ASRP_RD_WAIT;
                    cnt <= cyc(asrp_pkg::ACCESS_CYC + asrp_pkg::SYNC_CYC); // Access plus two sync stages
                end
                ASRP_RD_WAIT: begin
                    if (cnt == asrp_pkg::CNT_ONE) begin
                        state <= ASRP_IDLE;
                    end
                    cnt <= cnt - asrp_pkg::CNT_ONE;
                end
                ASRP_WR_SETUP: begin
                    state <= ASRP_WR_PULSE;
                    cnt <= cyc(asrp_pkg::WRITE_CYC);
                end
                ASRP_WR_PULSE: begin
                    if (cnt == asrp_pkg::CNT_ONE) begin
                        state <= ASRP_WR_HOLD;
                        cnt <= cyc(asrp_pkg::HOLD_CYC);
                    end else begin
                        cnt <= cnt - asrp_pkg::CNT_ONE;
                    end
                end
                ASRP_WR_HOLD: begin
                    if (cnt == asrp_pkg::CNT_ONE) begin
                        state <= ASRP_IDLE;
                    end
                    cnt <= cnt - asrp_pkg::CNT_ONE;
                end
                default: state <= ASRP_IDLE;
            endcase
        end
    end

    // Address and write data latched at acceptance, held through the cycle
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            word_addr <= '0;
            data_out <= '0;
        end else if (state == ASRP_IDLE && req_valid) begin
            word_addr <= req.addr;
            data_out <= req.wdata;
        end
    end

    // Select pins: both deasserted when idle so the memory drops to standby
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sel_lo_n <= 1'b1;
            sel_hi <= 1'b0;
        end else begin
            case (state)
                ASRP_RD_SETUP, ASRP_WR_SETUP, ASRP_WR_PULSE: begin
                    sel_lo_n <= 1'b0;
                    sel_hi <= 1'b1;
                end
                ASRP_RD_WAIT: begin
                    sel_lo_n <= (cnt == asrp_pkg::CNT_ONE);
                    sel_hi <= (cnt != asrp_pkg::CNT_ONE);
                end
                default: begin
                    sel_lo_n <= 1'b1;
                    sel_hi <= 1'b0;
                end
            endcase
        end
    end

    // Strobe and gate; write strobe alone ends the write, selects drop later
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            strobe_n <= 1'b1;
            gate_n <= 1'b1;
        end else begin
            strobe_n <= !(state == ASRP_WR_SETUP ||
                (state == ASRP_WR_PULSE && cnt != asrp_pkg::CNT_ONE));
            gate_n <= !(state == ASRP_RD_SETUP ||
                (state == ASRP_RD_WAIT && cnt != asrp_pkg::CNT_ONE));
        end
    end

    // Host drives data only for writes, through the hold period
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            data_oe <= 1'b0;
        end else begin
            data_oe <= (state == ASRP_WR_SETUP || state == ASRP_WR_PULSE);
        end
    end

    // Read data capture at the end of the access window
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rsp_valid <= 1'b0;
            rsp_data <= '0;
        end else begin
            rsp_valid <= (state == ASRP_RD_WAIT && cnt == asrp_pkg::CNT_ONE);
            if (state == ASRP_RD_WAIT && cnt == asrp_pkg::CNT_ONE) begin
                rsp_data <= data_sync;
            end
        end
    end

    property p_no_drive_on_read;
        @(posedge core_clk) disable iff (!reset_n)
        !pins.output_gate_n |-> !data_oe;
    endproperty
    a_no_drive_on_read: assert property (p_no_drive_on_read) else $error("host drives during read");

    property p_write_levels;
        @(posedge core_clk) disable iff (!reset_n)
        !pins.write_strobe_n |-> !pins.select_active_low && pins.select_active_high && data_oe;
    endproperty
    a_write_levels: assert property (p_write_levels) else $error("strobe low without select or data");

    property p_read_levels;
        @(posedge core_clk) disable iff (!reset_n)
        !pins.output_gate_n |-> pins.write_strobe_n && !pins.select_active_low && pins.select_active_high;
    endproperty
    a_read_levels: assert property (p_read_levels) else $error("gate low outside read");

    property p_selects_agree;
        @(posedge core_clk) disable iff (!reset_n)
        pins.select_active_low == !pins.select_active_high;
    endproperty
    a_selects_agree: assert property (p_selects_agree) else $error("selects disagree");

    sequence s_strobe_rise;
        !$past(pins.write_strobe_n) && pins.write_strobe_n;
    endsequence
    property p_data_hold;
        @(posedge core_clk) disable iff (!reset_n)
        s_strobe_rise |-> data_oe && $stable(data_out) && !pins.select_active_low;
    endproperty
    a_data_hold: assert property (p_data_hold) else $error("data or select changed at write end");

    property p_addr_stable;
        @(posedge core_clk) disable iff (!reset_n)
        !pins.select_active_low && !$past(pins.select_active_low) |-> $stable(pins.word_address_lines);
    endproperty
    a_addr_stable: assert property (p_addr_stable) else $error("address moved while selected");

    property p_pulse_len;
        @(posedge core_clk) disable iff (!reset_n)
        $fell(pins.write_strobe_n) |-> !pins.write_strobe_n [*2];
    endproperty
    a_pulse_len: assert property (p_pulse_len) else $error("write pulse too short");

    property p_read_done;
        @(posedge core_clk) disable iff (!reset_n)
        $fell(pins.output_gate_n) |-> ##[1:6] rsp_valid;
    endproperty
    a_read_done: assert property (p_read_done) else $error("read did not complete");

    property p_idle_standby;
        @(posedge core_clk) disable iff (!reset_n)
        (state == ASRP_IDLE) ##1 (state == ASRP_IDLE) |-> pins.select_active_low;
    endproperty
    a_idle_standby: assert property (p_idle_standby) else $error("selected while idle");
endmodule

/* src/asrp_pkg.sv */
// Package for the asynchronous static RAM host controller.
// Assumes a 100 MHz core clock and a 32K x 9 asynchronous SRAM on the pins.
package asrp_pkg;
    localparam int ADDR_W = 15;
    localparam int DATA_W = 9;
    localparam int WORDS = 32768;
    localparam int CLK_PERIOD_NS = 10;
    // Minimum access and write pulse times at the slowest speed grade
    localparam int ACCESS_NS = 20;
    localparam int WRITE_PULSE_NS = 15;
    localparam int DATA_HOLD_NS = 10;
    localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_CYC = (DATA_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SYNC_CYC = 2;
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [3:0] CNT_ONE = 4'h1;

    typedef struct packed {
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } asrp_req_t;

    typedef struct packed {
        logic select_active_low;
        logic select_active_high;
        logic output_gate_n;
        logic write_strobe_n;
        logic [ADDR_W-1:0] word_address_lines;
    } asrp_pins_t;
endpackage

/* src/asrp_sync.sv */
// Two-flop synchroniser for the data lines read back from the memory.
// Assumes the input is asynchronous to core_clk.
`timescale 1ns/1ns
module asrp_sync #(
    parameter int W = 9
) (
    input wire logic core_clk, // Core clock
    input wire logic reset_n, // Async reset, active low
    input wire logic [W-1:0] d, // Asynchronous input
    output logic [W-1:0] q // Synchronised output
);
    logic [W-1:0] stage1;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            stage1 <= '0;
            q <= '0;
        end else begin
            stage1 <= d;
            q <= stage1;
        end
    end
endmodule
